// file: hw/speed_ramp.sv
// Purpose: Ramps the speed limit toward its target
// Assumes: Time constants give clock cycles per unit step, less one
// Notes:   A time constant of zero steps once every clock cycle
`timescale 1ns/1ns
module speed_ramp #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Ramp settings
  input  wire logic [WIDTH-1:0] target,
  input  wire logic [15:0]      accel_tc,
  input  wire logic [15:0]      decel_tc,
  // Present value
  output logic      [WIDTH-1:0] value
);
  logic [15:0]      tick;
  logic [15:0]      next_tick;
  logic [WIDTH-1:0] next_value;
  logic [15:0]      tc;

  // One unit step each time the tick count reaches the active time constant
  always_comb
  begin
    next_value = value;
    next_tick  = tick;
    tc         = (target > value) ? accel_tc : decel_tc;
    if (target == value)
      next_tick = 16'h0000;
    else if (tick >= tc)
    begin
      next_tick  = 16'h0000;
      next_value = (target > value) ? value + 1'b1 : value - 1'b1;
    end
    else
      next_tick = tick + 16'h0001;
  end

  // Registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      value <= '0;
      tick  <= 16'h0000;
    end
    else
    begin
      value <= next_value;
      tick  <= next_tick;
    end
  end
endmodule : speed_ramp

// file: hw/torque_position_mode_switch.sv
// Purpose: Torque/position control-mode switching with zero-speed gating
// Assumes: Contact inputs arrive asynchronously; APB register access
// Notes:   Parameters are stored here; starred ones commit on reset request
`timescale 1ns/1ns

module torque_position_mode_switch
  import tpsw_pkg::*;
#(
  parameter int SPEED_W = 16,
  parameter int ERR_W   = 32
) (
  // APB
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Contacts and motion status
  input  wire logic               mode_switch_contact,
  input  wire logic               speed_select_low,
  input  wire logic               zero_speed_flag,
  input  wire logic [SPEED_W-1:0] analog_speed_limit_input,
  // Position error pulses
  input  wire logic               pos_err_up,
  input  wire logic               pos_err_down,
  // Outputs to the loops
  output logic                    position_mode,
  output logic [SPEED_W-1:0]      speed_limit,
  output logic [ERR_W-1:0]        pos_err_count,
  output logic [31:0]             target_position,
  output logic                    travel_direction_symbol,
  output logic                    forced_stop_decel_symbol
);
  import tpsw_pkg::*;

  // Synchronisers: three stages, a change counts when stages two and three agree
  logic [2:0] sync_mode;
  logic [2:0] sync_sel;
  logic [2:0] sync_zero;
  logic       mode_in;
  logic       sel_in;
  logic       zero_in;
  logic       next_mode_in;
  logic       next_sel_in;
  logic       next_zero_in;

  always_comb
  begin
    next_mode_in = (sync_mode[1] == sync_mode[2]) ? sync_mode[2] : mode_in;
    next_sel_in  = (sync_sel[1]  == sync_sel[2])  ? sync_sel[2]  : sel_in;
    next_zero_in = (sync_zero[1] == sync_zero[2]) ? sync_zero[2] : zero_in;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_mode <= 3'h0;
      sync_sel  <= 3'h0;
      sync_zero <= 3'h0;
      mode_in   <= 1'b0;
      sel_in    <= 1'b0;
      zero_in   <= 1'b0;
    end
    else
    begin
      sync_mode <= {sync_mode[1:0], mode_switch_contact};
      sync_sel  <= {sync_sel[1:0], speed_select_low};
      sync_zero <= {sync_zero[1:0], zero_speed_flag};
      mode_in   <= next_mode_in;
      sel_in    <= next_sel_in;
      zero_in   <= next_zero_in;
    end
  end

  // Parameter storage: written value and the value in force
  logic [31:0]  mode_param;
  logic [31:0]  func_param;
  logic [31:0]  dir_param;
  logic [31:0]  mode_active;
  logic [31:0]  func_active;
  logic [31:0]  dir_active;
  logic [15:0]  speed_one;
  logic [15:0]  accel_tc;
  logic [15:0]  decel_tc;
  logic [31:0]  target_pos;
  logic [31:0]  next_mode_param;
  logic [31:0]  next_func_param;
  logic [31:0]  next_dir_param;
  logic [31:0]  next_mode_active;
  logic [31:0]  next_func_active;
  logic [31:0]  next_dir_active;
  logic [15:0]  next_speed_one;
  logic [15:0]  next_accel_tc;
  logic [15:0]  next_decel_tc;
  logic [31:0]  next_target_pos;
  logic         wr_en;
  logic         sw_reset_req;
  logic         ctrl_reset_req;

  assign wr_en          = psel & penable & pwrite;
  assign sw_reset_req   = wr_en && (paddr == OFF_CONTROL) && pwdata[CTL_SW_RESET];
  assign ctrl_reset_req = wr_en && (paddr == OFF_CONTROL) && pwdata[CTL_CTRL_RESET];

  // Register writes and commit of starred parameters
  always_comb
  begin
    next_mode_param  = mode_param;
    next_func_param  = func_param;
    next_dir_param   = dir_param;
    next_speed_one   = speed_one;
    next_accel_tc    = accel_tc;
    next_decel_tc    = decel_tc;
    next_target_pos  = target_pos;
    next_mode_active = mode_active;
    next_func_active = func_active;
    next_dir_active  = dir_active;
    if (wr_en)
    begin
      case (paddr)
        OFF_MODE_PARAM: next_mode_param = pwdata;
        OFF_FUNC_PARAM: next_func_param = pwdata;
        OFF_DIR_PARAM:  next_dir_param  = pwdata;
        OFF_SPEED_ONE:  next_speed_one  = pwdata[15:0];
        OFF_ACCEL:      next_accel_tc   = pwdata[15:0];
        OFF_DECEL:      next_decel_tc   = pwdata[15:0];
        OFF_TARGET_POS: next_target_pos = pwdata;
        default:        next_target_pos = target_pos;
      endcase
    end
    // Single-star words commit on either reset request
    if (sw_reset_req || ctrl_reset_req)
    begin
      next_mode_active = mode_param;
      next_dir_active  = dir_param;
    end
    // Double-star word commits on software reset only
    if (sw_reset_req)
      next_func_active = func_param;
  end

  // Power-up loads factory values; no user setting means these stand
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_param  <= INIT_MODE_PARAM;
      func_param  <= INIT_FUNC_PARAM;
      dir_param   <= INIT_DIR_PARAM;
      mode_active <= INIT_MODE_PARAM;
      func_active <= INIT_FUNC_PARAM;
      dir_active  <= INIT_DIR_PARAM;
      speed_one   <= INIT_SPEED_ONE;
      accel_tc    <= INIT_ACCEL;
      decel_tc    <= INIT_DECEL;
      target_pos  <= 32'h0000_0000;
    end
    else
    begin
      mode_param  <= next_mode_param;
      func_param  <= next_func_param;
      dir_param   <= next_dir_param;
      mode_active <= next_mode_active;
      func_active <= next_func_active;
      dir_active  <= next_dir_active;
      speed_one   <= next_speed_one;
      accel_tc    <= next_accel_tc;
      decel_tc    <= next_decel_tc;
      target_pos  <= next_target_pos;
    end
  end

  // Digit decode: sub-field n is bits 4n+3..4n
  logic [3:0] mode_digit;
  logic [3:0] stop_digit;
  logic       tp_active;
  assign mode_digit = mode_active[MODE_DIGIT*DIGIT_W +: DIGIT_W];
  assign stop_digit = func_active[FORCED_STOP_DIGIT*DIGIT_W +: DIGIT_W];
  assign tp_active  = (mode_digit == MODE_TORQUE_POS);

  // Mode switch: a contact edge is acted on only if zero speed holds at that edge.
  // An edge seen while moving is dropped; the contact must toggle again later.
  ctrl_mode_t mode;
  ctrl_mode_t next_mode;
  logic       mode_in_d;
  logic       armed;
  logic       next_armed;
  logic       contact_edge;
  assign contact_edge = mode_in ^ mode_in_d;

  always_comb
  begin
    next_mode  = mode;
    next_armed = armed;
    if (!tp_active)
    begin
      next_mode  = CM_TORQUE;
      next_armed = 1'b0;
    end
    else if (contact_edge)
    begin
      if (zero_in)
      begin
        next_mode  = mode_in ? CM_POSITION : CM_TORQUE;
        next_armed = 1'b0;
      end
      else
        next_armed = 1'b1;
    end
    // A stale edge stays unserved; only a fresh edge at zero speed, or a mode digit other than 5, clears it
    case (mode)
      CM_TORQUE:   next_mode = next_mode;
      CM_POSITION: next_mode = next_mode;
      default:     next_mode = CM_TORQUE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode      <= CM_TORQUE;
      mode_in_d <= 1'b0;
      armed     <= 1'b0;
    end
    else
    begin
      mode      <= next_mode;
      mode_in_d <= mode_in;
      armed     <= next_armed;
    end
  end

  // Position error counter, cleared on leaving position mode
  logic [ERR_W-1:0] next_err;
  always_comb
  begin
    next_err = pos_err_count;
    if (mode == CM_POSITION && next_mode == CM_TORQUE)
      next_err = '0;
    else if (mode == CM_POSITION && (pos_err_up ^ pos_err_down))
      next_err = pos_err_up ? pos_err_count + 1'b1 : pos_err_count - 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pos_err_count <= '0;
    else
      pos_err_count <= next_err;
  end

  // Speed limit source and ramp
  logic [SPEED_W-1:0] limit_target;
  assign limit_target = sel_in ? speed_one[SPEED_W-1:0] : analog_speed_limit_input;

  speed_ramp #(
    .WIDTH    (SPEED_W)
  ) u_ramp (
    .pclk     (pclk),
    .presetn  (presetn),
    .target   (limit_target),
    .accel_tc (accel_tc),
    .decel_tc (decel_tc),
    .value    (speed_limit)
  );

  // Outputs
  assign position_mode            = (mode == CM_POSITION);
  assign target_position          = target_pos;
  assign travel_direction_symbol  = dir_active[0];
  assign forced_stop_decel_symbol = (stop_digit == 4'h1);

  // APB read: zero wait states, unmapped reads zero with error
  logic mapped;
  always_comb
  begin
    mapped = 1'b1;
    prdata = 32'h0000_0000;
    case (paddr)
      OFF_MODE_PARAM: prdata = mode_param;
      OFF_FUNC_PARAM: prdata = func_param;
      OFF_DIR_PARAM:  prdata = dir_param;
      OFF_SPEED_ONE:  prdata = {16'h0000, speed_one};
      OFF_ACCEL:      prdata = {16'h0000, accel_tc};
      OFF_DECEL:      prdata = {16'h0000, decel_tc};
      OFF_STATUS:     prdata = {27'h0, sel_in, armed, zero_in, tp_active, position_mode};
      OFF_CONTROL:    prdata = 32'h0000_0000;
      OFF_TARGET_POS: prdata = target_pos;
      OFF_OBJ_INDEX:  prdata = {OBJ_INDEX_MAX, OBJ_TARGET_POS};
      OFF_LIMIT_NOW:  prdata = {{(32-SPEED_W){1'b0}}, speed_limit};
      default:        mapped = 1'b0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
endmodule : torque_position_mode_switch

// file: hw/tpsw_pkg.sv
// Purpose: Shared constants for the torque/position mode switch block
// Assumes: APB slave, 32-bit data, one clock
// Notes:   Byte offsets are word aligned
package tpsw_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_MODE_PARAM   = 8'h00; // Control-mode parameter word (digit coded)
  localparam logic [7:0] OFF_FUNC_PARAM   = 8'h04; // Function selection word (forced-stop digit)
  localparam logic [7:0] OFF_DIR_PARAM    = 8'h08; // Travel direction selection
  localparam logic [7:0] OFF_SPEED_ONE    = 8'h0c; // Internal speed one
  localparam logic [7:0] OFF_ACCEL        = 8'h10; // Acceleration time constant
  localparam logic [7:0] OFF_DECEL        = 8'h14; // Deceleration time constant
  localparam logic [7:0] OFF_STATUS       = 8'h18; // Status (read only)
  localparam logic [7:0] OFF_CONTROL      = 8'h1c; // Resets and parameter commit
  localparam logic [7:0] OFF_TARGET_POS   = 8'h20; // Object 607Ah target position
  localparam logic [7:0] OFF_OBJ_INDEX    = 8'h24; // Index of the target position object
  localparam logic [7:0] OFF_LIMIT_NOW    = 8'h28; // Present ramped speed limit

  // Digit coding: each hex digit is a sub-field, digit 0 lowest
  localparam int DIGIT_W                 = 4;
  localparam int MODE_DIGIT              = 0;
  localparam int FORCED_STOP_DIGIT       = 3;
  localparam logic [3:0] MODE_TORQUE_POS = 4'h5;

  // Factory initial values
  localparam logic [31:0] INIT_MODE_PARAM = 32'h0000_0005;
  localparam logic [31:0] INIT_FUNC_PARAM = 32'h0000_1000; // Forced-stop digit = 1h, enabled
  localparam logic [31:0] INIT_DIR_PARAM  = 32'h0000_0000; // Positive direction
  localparam logic [15:0] INIT_SPEED_ONE  = 16'h0064;
  localparam logic [15:0] INIT_ACCEL      = 16'h0000;
  localparam logic [15:0] INIT_DECEL      = 16'h0000;

  // Object dictionary
  localparam logic [15:0] OBJ_INDEX_MIN   = 16'h0000;
  localparam logic [15:0] OBJ_INDEX_MAX   = 16'hffff;
  localparam logic [15:0] OBJ_TARGET_POS  = 16'h607a;

  // Control register bits
  localparam int CTL_SW_RESET   = 0;
  localparam int CTL_CTRL_RESET = 1;

  // Status register bits
  localparam int ST_POS_MODE    = 0;
  localparam int ST_TP_ACTIVE   = 1;
  localparam int ST_ZERO_SPEED  = 2;
  localparam int ST_ARMED       = 3;
  localparam int ST_USE_PRESET  = 4;

  // Control mode
  typedef enum logic [1:0] {
    CM_TORQUE   = 2'b01,
    CM_POSITION = 2'b10
  } ctrl_mode_t;
endpackage : tpsw_pkg

// file: tb/contact_panel.sv
// Purpose: External contacts and motion feedback
// Assumes: Bench sets wanted levels just after an edge
// Notes:   Levels reach the pins one edge later, as a real switch would
`timescale 1ns/1ns
module contact_panel (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Wanted state
  input  wire logic want_pos,
  input  wire logic want_preset,
  input  wire logic moving,
  input  wire logic jog,
  input  wire logic back,
  // Pins
  output logic      mode_switch_contact,
  output logic      speed_select_low,
  output logic      zero_speed_flag,
  output logic      pos_err_up,
  output logic      pos_err_down
);
  // Zero flag only at standstill; jog gives one pulse per cycle held
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {mode_switch_contact, speed_select_low, zero_speed_flag, pos_err_up, pos_err_down} <= 5'b00100;
    else
      {mode_switch_contact, speed_select_low, zero_speed_flag, pos_err_up, pos_err_down} <=
        {want_pos, want_preset, !moving, jog && !back, jog && back};
endmodule : contact_panel

// file: tb/testbench.sv
// Purpose: Self-checking bench for the mode switch
// Assumes: Zero-wait APB slave, contacts from contact_panel
// Notes:   Read results are queued and checked by a bus watcher
`timescale 1ns/1ns
module testbench;
  import tpsw_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, pos_err_count, target_position, t;
  logic        mode_switch_contact, speed_select_low, zero_speed_flag;
  logic        pos_err_up, pos_err_down, position_mode;
  logic        travel_direction_symbol, forced_stop_decel_symbol;
  logic        want_pos, want_preset, moving, jog, back;
  logic [15:0] analog_speed_limit_input, speed_limit, v;
  logic [32:0] expq[$];
  int          miscompares, compares, n, k, d;

  // Design and the panel in front of it
  torque_position_mode_switch i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .mode_switch_contact, .speed_select_low, .zero_speed_flag,
    .analog_speed_limit_input, .pos_err_up, .pos_err_down, .position_mode,
    .speed_limit, .pos_err_count, .target_position, .travel_direction_symbol,
    .forced_stop_decel_symbol
  );
  contact_panel i_panel (
    .pclk, .presetn, .want_pos, .want_preset, .moving, .jog, .back,
    .mode_switch_contact, .speed_select_low, .zero_speed_flag, .pos_err_up, .pos_err_down
  );

  // Bus clock
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic finish_test;
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test

  // One transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // No assumed latency: only the watchdog ends a wait that never completes
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
    expq.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic wait_mode(input logic m);
    for (n = 0; n < 40 && position_mode !== m; n++)
      @(negedge pclk);
    chk("position_mode", {31'h0, position_mode}, {31'h0, m});
  endtask : wait_mode

  task automatic wait_lim(input logic [15:0] e);
    for (n = 0; n < 3000 && speed_limit !== e; n++)
      @(negedge pclk);
    chk("speed_limit", {16'h0, speed_limit}, {16'h0, e});
  endtask : wait_lim

  // Watcher: oldest queued note against each completed read
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
    begin
      chk("prdata", prdata, expq[0][31:0]);
      chk("pslverr", {31'h0, pslverr}, {31'h0, expq[0][32]});
      void'(expq.pop_front());
    end

  // Watchdog
  initial
  begin
    repeat (30000) @(posedge pclk);
    miscompares++;
    finish_test();
  end

  initial
  begin
    void'($urandom(4));
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {want_pos, want_preset, moving, jog, back} = '0;
    analog_speed_limit_input = 16'h0;
    miscompares = 0;
    compares = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // Factory values, index word, unmapped place, status
    rd(OFF_MODE_PARAM, INIT_MODE_PARAM, 1'b0);
    rd(OFF_FUNC_PARAM, INIT_FUNC_PARAM, 1'b0);
    rd(OFF_DIR_PARAM, INIT_DIR_PARAM, 1'b0);
    rd(OFF_SPEED_ONE, {16'h0, INIT_SPEED_ONE}, 1'b0);
    rd(OFF_OBJ_INDEX, {OBJ_INDEX_MAX, OBJ_TARGET_POS}, 1'b0);
    rd(8'h30, 32'h0, 1'b1);
    rd(OFF_STATUS, 32'h6, 1'b0);
    chk("dir_sym", {31'h0, travel_direction_symbol}, 32'h0);
    chk("stop_sym", {31'h0, forced_stop_decel_symbol}, 32'h1);
    t = $urandom;
    apb(1'b1, OFF_TARGET_POS, t); // Written once, as a tool keeps off cyclic words
    rd(OFF_TARGET_POS, t, 1'b0);
    chk("target", target_position, t);
    // Switch at zero speed, count pulses, leave position
    @(posedge pclk);
    want_pos <= 1'b1;
    wait_mode(1'b1);
    k = $urandom_range(3, 9);
    for (int i = 0; i <= k; i++)
    begin
      @(posedge pclk);
      {jog, back} <= {1'b1, i == k};
      @(posedge pclk);
      jog <= 1'b0;
    end
    repeat (3) @(negedge pclk);
    chk("err_count", pos_err_count, k - 1);
    want_pos <= 1'b0;
    wait_mode(1'b0);
    chk("err_count", pos_err_count, 32'h0);
    // Toggle while moving is dropped for good
    @(posedge pclk);
    moving <= 1'b1;
    repeat (8) @(posedge pclk);
    want_pos <= 1'b1;
    repeat (20) @(posedge pclk);
    moving <= 1'b0;
    repeat (20) @(negedge pclk);
    chk("position_mode", {31'h0, position_mode}, 32'h0);
    rd(OFF_STATUS, 32'he, 1'b0);
    @(posedge pclk);
    want_pos <= 1'b0;
    repeat (10) @(posedge pclk);
    want_pos <= 1'b1;
    wait_mode(1'b1);
    want_pos <= 1'b0;
    wait_mode(1'b0);
    // Limit source and ramping, fast then with time constants
    v = $urandom_range(32, 512);
    @(posedge pclk);
    analog_speed_limit_input <= v;
    wait_lim(v);
    want_preset <= 1'b1;
    wait_lim(INIT_SPEED_ONE);
    t = $urandom_range(32, 512);
    apb(1'b1, OFF_SPEED_ONE, t);
    wait_lim(t[15:0]);
    rd(OFF_LIMIT_NOW, t, 1'b0);
    apb(1'b1, OFF_ACCEL, 32'h3);
    apb(1'b1, OFF_DECEL, 32'h2);
    // Falling steps take decel+1 cycles, rising accel+1; a few more for the select sync
    d = (t[15:0] > v) ? 3 * (t[15:0] - v) : 4 * (v - t[15:0]);
    want_preset <= 1'b0;
    wait_lim(v);
    chk("ramp_time", {31'h0, n >= d && n <= d + 10}, 32'h1);
    // Starred words wait for their reset
    apb(1'b1, OFF_DIR_PARAM, 32'h1);
    chk("dir_sym", {31'h0, travel_direction_symbol}, 32'h0);
    apb(1'b1, OFF_CONTROL, 32'h2);
    @(negedge pclk);
    chk("dir_sym", {31'h0, travel_direction_symbol}, 32'h1);
    apb(1'b1, OFF_FUNC_PARAM, 32'h2000);
    apb(1'b1, OFF_CONTROL, 32'h2);
    @(negedge pclk);
    chk("stop_sym", {31'h0, forced_stop_decel_symbol}, 32'h1);
    apb(1'b1, OFF_CONTROL, 32'h1);
    @(negedge pclk);
    chk("stop_sym", {31'h0, forced_stop_decel_symbol}, 32'h0);
    // Mode digit other than 5 keeps torque control
    apb(1'b1, OFF_MODE_PARAM, 32'h50);
    apb(1'b1, OFF_CONTROL, 32'h2);
    want_pos <= 1'b1;
    repeat (20) @(negedge pclk);
    chk("position_mode", {31'h0, position_mode}, 32'h0);
    finish_test();
  end
endmodule : testbench

// file: tb/tpsw_assertions.sv
// Purpose: Port checks for the torque/position mode switch
// Assumes: One clock, asynchronous active-low reset
// Notes:   A loose zero-speed window allows for input sync delay
`timescale 1ns/1ns
module tpsw_checker
  import tpsw_pkg::*;
#(
  parameter int SPEED_W = 16,
  parameter int ERR_W   = 32
) (
  // APB
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  // Motion and outputs
  input wire logic               zero_speed_flag,
  input wire logic               pos_err_up,
  input wire logic               pos_err_down,
  input wire logic               position_mode,
  input wire logic [SPEED_W-1:0] speed_limit,
  input wire logic [ERR_W-1:0]   pos_err_count,
  input wire logic               travel_direction_symbol,
  input wire logic               forced_stop_decel_symbol
);
  logic       acc;
  logic [3:0] since_zero;
  logic [3:0] next_since_zero;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Access phase of a transfer
  assign acc = psel && penable;
  // Cycles since zero speed was last seen; saturates so long runs stay flagged
  always_comb
    next_since_zero = zero_speed_flag ? 4'h0 : since_zero + {3'h0, since_zero != 4'hf};
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      since_zero <= 4'h0;
    else
      since_zero <= next_since_zero;
  index_read_a: assert property (acc && !pwrite && paddr == OFF_OBJ_INDEX
    |-> prdata == {OBJ_INDEX_MAX, OBJ_TARGET_POS}) else $error("index read wrong");
  status_mode_a: assert property (acc && !pwrite && paddr == OFF_STATUS
    |-> prdata[ST_POS_MODE] == position_mode) else $error("status mode bit wrong");
  leave_clear_a: assert property ($fell(position_mode) |-> pos_err_count == '0)
    else $error("count kept on leaving position");
  torque_zero_a: assert property (!position_mode && !$past(position_mode)
    |-> pos_err_count == '0) else $error("count moves in torque");
  zero_gate_a: assert property ($changed(position_mode) |-> since_zero < 4'd10)
    else $error("mode changed while moving");
  count_step_a: assert property ($past(position_mode) && position_mode
    && $past(pos_err_up) && !$past(pos_err_down) |-> pos_err_count == $past(pos_err_count) + 1'b1)
    else $error("count step wrong");
  ramp_step_a: assert property ($changed(speed_limit) |-> speed_limit == $past(speed_limit) + 1'b1
    || speed_limit + 1'b1 == $past(speed_limit)) else $error("limit jumped");
  dir_commit_a: assert property ($changed(travel_direction_symbol)
    |-> $past(acc && pwrite && paddr == OFF_CONTROL && (pwdata[CTL_SW_RESET] || pwdata[CTL_CTRL_RESET])))
    else $error("direction without reset");
  func_commit_a: assert property ($changed(forced_stop_decel_symbol)
    |-> $past(acc && pwrite && paddr == OFF_CONTROL && pwdata[CTL_SW_RESET]))
    else $error("double-star without soft reset");
endmodule : tpsw_checker

bind torque_position_mode_switch tpsw_checker #(.SPEED_W(SPEED_W), .ERR_W(ERR_W)) i_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .zero_speed_flag, .pos_err_up, .pos_err_down, .position_mode, .speed_limit,
  .pos_err_count, .travel_direction_symbol, .forced_stop_decel_symbol
);
